// ==== core/sec_cfg.svh ====
// What this block does
// - opcodes start with eight bits; 0000X110 sets, 0000X100 clears the write latch
// - 0000X101 shifts the status byte out until chip select rises
// - 0000X001 plus one byte alters only the two protect bits
// - array read ends 011, array write ends 010; opcode bit 3 is address bit eight
// - an undefined opcode makes the device ignore everything until deselect
// - only the latch-set command sets the write latch; writes need it first
// - latch set or clear takes effect when chip select rises after the opcode
// - latch clears on power-up, clear command, write completion, or protect pin low
// - status read is accepted at any time, even while programming
// - protect bits read frozen during programming; latch and busy read live
// - status bits 7 to 4 always read as one
// - busy flag is one exactly while a programming cycle runs
// - with the write latch at zero, array and status writes are refused
// - protect bits reset to 00, set only by status write, blocked by protect pin
// - protect code 00 none, 01 upper quarter, 10 upper half, 11 whole array
// - status write needs deselect right after data bit 0, else it is dropped
// - accepted status write runs a timed cycle, then busy clears
// - status write refused on latch zero, busy, bad deselect or protect pin low
// - array read loads address, streams bytes, increments and wraps to zero
// - address width nine, eight or seven bits; unused upper bits ignored
// - array read refused while busy; deselect may end it at any bit
// - array write: opcode, address, data bytes; byte-boundary deselect starts timed cycle
// - extra write bytes step through the page and wrap to its start
// - array write refused on latch zero, busy, bad boundary, pin low, protected page
// - all fields MSB first; input sampled on rising, output driven from falling edge
`ifndef SEC_CFG_SVH
`define SEC_CFG_SVH

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define SEC_OP_HI 4'h0
`define SEC_OP_LATCH_SET 3'h6
`define SEC_OP_LATCH_CLEAR 3'h4
`define SEC_OP_STATUS_READ 3'h5
`define SEC_OP_STATUS_WRITE 3'h1
`define SEC_OP_ARRAY_READ 3'h3
`define SEC_OP_ARRAY_WRITE 3'h2
`define SEC_OP_ADDR_BIT 3

// ----------------------------------------
// status byte layout
// ----------------------------------------
`define SEC_ST_ONES 4'hF
`define SEC_ST_BUSY 0
`define SEC_ST_WEL 1
`define SEC_ST_BP_LO 2
`define SEC_ST_BP_HI 3
`define SEC_BP_RST 2'h0
`define SEC_BP_QUARTER 2'h1
`define SEC_BP_HALF 2'h2
`define SEC_BP_ALL 2'h3

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define SEC_ADDR_W 9
`define SEC_PAGE_BITS 4
`define SEC_PAGE_BYTES 5'h10
`define SEC_FIFO_DEPTH 16
`define SEC_CLK_MHZ 40
`define SEC_PROG_TIME_US 1000
`define SEC_PROG_CYCLES (`SEC_PROG_TIME_US * `SEC_CLK_MHZ)
`define SEC_DRAIN_PACE 2'h3
`define SEC_PIN_RST 4'h9

`endif

// ==== core/sec_pkg.sv ====
package sec_pkg;
  typedef enum logic [3:0] {
    SPI_IDLE,
    SPI_OPCODE,
    SPI_WAIT_CS,
    SPI_STATUS_READ,
    SPI_STATUS_WRITE,
    SPI_ADDR,
    SPI_ARRAY_READ,
    SPI_ARRAY_WRITE,
    SPI_IGNORE
  } sec_spi_state_type;

  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_LOAD,
    PROG_TIME
  } sec_prog_state_type;
endpackage

// ==== core/sec_core.sv ====
`include "sec_cfg.svh"

// ----------------------------------------
// write fifo
// ----------------------------------------
module sec_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  assign o_ready = (count_reg != CW'(DEPTH));
  assign o_valid = (count_reg != '0);
  assign o_data = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
    end
  end
endmodule

// ----------------------------------------
// eeprom command core
// ----------------------------------------
module sec_core #(
  parameter int ADDR_W = `SEC_ADDR_W,
  parameter int PROG_CYCLES = `SEC_PROG_CYCLES,
  parameter int FIFO_DEPTH = `SEC_FIFO_DEPTH
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SDI,
  input wire logic I_WP_N,
  output logic O_SDO,
  output logic O_SDO_OE_N
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PB = `SEC_PAGE_BITS;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_rst;
  logic cs_prev_reg;
  logic sck_prev_reg;
  assign pin_raw = {I_WP_N, I_SDI, I_SCK, I_CS_N};
  assign pin_rst = `SEC_PIN_RST;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          pin_meta_reg[g] <= pin_rst[g];
          pin_sync_reg[g] <= pin_rst[g];
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  wire cs_n = pin_sync_reg[0];
  wire sck = pin_sync_reg[1];
  wire sdi = pin_sync_reg[2];
  wire wp_n = pin_sync_reg[3];

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_n;
      sck_prev_reg <= sck;
    end
  end

  // mode 0 and mode 3 both sample on rising and shift out on falling edges
  wire cs_fall = !cs_n && cs_prev_reg;
  wire cs_rise = cs_n && !cs_prev_reg;
  wire sck_rise = !cs_n && sck && !sck_prev_reg;
  wire sck_fall = !cs_n && !sck && sck_prev_reg;

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  sec_pkg::sec_spi_state_type state_reg;
  sec_pkg::sec_spi_state_type state_next;
  sec_pkg::sec_prog_state_type prog_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] out_reg;
  logic wel_reg;
  logic [1:0] bp_reg;
  logic [1:0] bp_pend_reg;
  logic got_data_reg;
  logic over_reg;
  logic [7:0] pbuf [0:(1<<PB)-1];
  logic [(1<<PB)-1:0] pmask_reg;
  logic [PB-1:0] col_reg;
  logic [4:0] load_idx_reg;
  logic stat_job_reg;
  logic [31:0] prog_cnt_reg;
  logic [1:0] pace_reg;
  logic [7:0] mem [0:DEPTH-1];
  logic f_in_ready;
  logic f_out_valid;
  logic [ADDR_W+7:0] f_out_data;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [7:0] rx_byte = {shift_reg[6:0], sdi};
  wire byte_done = sck_rise && (bit_cnt_reg == 3'h7);
  wire op_ok = (rx_byte[7:4] == `SEC_OP_HI);
  wire [2:0] op_lo = rx_byte[2:0];
  wire is_set = op_ok && (op_lo == `SEC_OP_LATCH_SET);
  wire is_clr = op_ok && (op_lo == `SEC_OP_LATCH_CLEAR);
  wire is_srd = op_ok && (op_lo == `SEC_OP_STATUS_READ);
  wire is_swr = op_ok && (op_lo == `SEC_OP_STATUS_WRITE);
  wire is_ard = op_ok && (op_lo == `SEC_OP_ARRAY_READ);
  wire is_awr = op_ok && (op_lo == `SEC_OP_ARRAY_WRITE);
  wire op_valid = is_set || is_clr || is_srd || is_swr || is_ard || is_awr;
  wire busy = (prog_reg != sec_pkg::PROG_IDLE);
  // upper bits beyond ADDR_W drop out here
  wire [8:0] addr_full = {op_reg[`SEC_OP_ADDR_BIT], rx_byte};
  wire [ADDR_W-1:0] addr_in = addr_full[ADDR_W-1:0];
  wire [1:0] top2 = addr_in[ADDR_W-1 -: 2];
  wire prot = (bp_reg == `SEC_BP_ALL) ||
              (bp_reg == `SEC_BP_HALF && top2[1]) ||
              (bp_reg == `SEC_BP_QUARTER && top2 == 2'h3);
  wire op_write = (op_reg[2:0] == `SEC_OP_ARRAY_WRITE);
  wire [ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
  wire [7:0] status = {`SEC_ST_ONES, bp_reg[1], bp_reg[0], wel_reg, busy};

  // deselect must land between the last data bit and the next rising edge
  wire wr_commit = cs_rise && (state_reg == sec_pkg::SPI_ARRAY_WRITE) &&
                   (bit_cnt_reg == 3'h0) && got_data_reg &&
                   wel_reg && wp_n && !busy;
  wire st_commit = cs_rise && (state_reg == sec_pkg::SPI_STATUS_WRITE) &&
                   (bit_cnt_reg == 3'h0) && got_data_reg && !over_reg &&
                   wel_reg && wp_n && !busy;

  // ----------------------------------------
  // serial command engine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sec_pkg::SPI_IDLE: begin
        if (cs_fall) begin
          state_next = sec_pkg::SPI_OPCODE;
        end
      end
      sec_pkg::SPI_OPCODE: begin
        if (byte_done) begin
          if (!op_valid) begin
            state_next = sec_pkg::SPI_IGNORE;
          end else if (is_set || is_clr) begin
            state_next = sec_pkg::SPI_WAIT_CS;
          end else if (is_srd) begin
            state_next = sec_pkg::SPI_STATUS_READ;
          end else if (busy) begin
            state_next = sec_pkg::SPI_IGNORE;
          end else if (is_swr) begin
            state_next = sec_pkg::SPI_STATUS_WRITE;
          end else begin
            state_next = sec_pkg::SPI_ADDR;
          end
        end
      end
      sec_pkg::SPI_WAIT_CS: begin
        if (sck_rise) begin
          state_next = sec_pkg::SPI_IGNORE;
        end
      end
      sec_pkg::SPI_ADDR: begin
        if (byte_done) begin
          if (!op_write) begin
            state_next = sec_pkg::SPI_ARRAY_READ;
          end else if (prot) begin
            state_next = sec_pkg::SPI_IGNORE;
          end else begin
            state_next = sec_pkg::SPI_ARRAY_WRITE;
          end
        end
      end
      sec_pkg::SPI_STATUS_READ,
      sec_pkg::SPI_STATUS_WRITE,
      sec_pkg::SPI_ARRAY_READ,
      sec_pkg::SPI_ARRAY_WRITE,
      sec_pkg::SPI_IGNORE: begin
        state_next = state_reg;
      end
      default: begin
        state_next = sec_pkg::SPI_IDLE;
      end
    endcase
    if (cs_n) begin
      state_next = sec_pkg::SPI_IDLE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_reg <= sec_pkg::SPI_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (cs_n) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        shift_reg <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      op_reg <= 8'h00;
      addr_reg <= '0;
      out_reg <= 8'h00;
    end else if (byte_done) begin
      if (state_reg == sec_pkg::SPI_OPCODE) begin
        op_reg <= rx_byte;
        out_reg <= status;
      end else if (state_reg == sec_pkg::SPI_STATUS_READ) begin
        out_reg <= status;
      end else if (state_reg == sec_pkg::SPI_ADDR) begin
        addr_reg <= addr_in;
        out_reg <= mem[addr_in];
      end else if (state_reg == sec_pkg::SPI_ARRAY_READ) begin
        addr_reg <= addr_inc;
        out_reg <= mem[addr_inc];
      end
    end
  end

  // output only from falling edges; oe stays off until a read phase begins
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_SDO <= 1'b0;
      O_SDO_OE_N <= 1'b1;
    end else if (cs_n) begin
      O_SDO_OE_N <= 1'b1;
    end else if (sck_fall && (state_reg == sec_pkg::SPI_STATUS_READ ||
                              state_reg == sec_pkg::SPI_ARRAY_READ)) begin
      O_SDO <= out_reg[~bit_cnt_reg];
      O_SDO_OE_N <= 1'b0;
    end
  end

  // ----------------------------------------
  // write data capture
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      got_data_reg <= 1'b0;
      over_reg <= 1'b0;
      bp_pend_reg <= `SEC_BP_RST;
      pmask_reg <= '0;
      col_reg <= '0;
    end else if (state_reg == sec_pkg::SPI_OPCODE) begin
      got_data_reg <= 1'b0;
      over_reg <= 1'b0;
    end else if (byte_done && state_reg == sec_pkg::SPI_ADDR && !busy) begin
      pmask_reg <= '0;
      col_reg <= rx_byte[PB-1:0];
    end else if (byte_done && state_reg == sec_pkg::SPI_STATUS_WRITE) begin
      got_data_reg <= 1'b1;
      over_reg <= got_data_reg;
      bp_pend_reg <= {rx_byte[`SEC_ST_BP_HI], rx_byte[`SEC_ST_BP_LO]};
    end else if (byte_done && state_reg == sec_pkg::SPI_ARRAY_WRITE) begin
      got_data_reg <= 1'b1;
      pmask_reg[col_reg] <= 1'b1;
      col_reg <= col_reg + 1'b1;
    end
  end

  // later bytes at the same column simply overwrite the earlier ones
  always_ff @(posedge I_REF_CLK) begin
    if (byte_done && state_reg == sec_pkg::SPI_ARRAY_WRITE) begin
      pbuf[col_reg] <= rx_byte;
    end
  end

  // ----------------------------------------
  // write latch and protect bits
  // ----------------------------------------
  wire prog_done = (prog_reg == sec_pkg::PROG_TIME) && (prog_cnt_reg == 32'h0) && !f_out_valid;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      wel_reg <= 1'b0;
    end else if (!wp_n) begin
      wel_reg <= 1'b0;
    end else if (cs_rise && state_reg == sec_pkg::SPI_WAIT_CS && op_reg[2:0] == `SEC_OP_LATCH_SET) begin
      wel_reg <= 1'b1;
    end else if (cs_rise && state_reg == sec_pkg::SPI_WAIT_CS) begin
      wel_reg <= 1'b0;
    end else if (prog_done) begin
      wel_reg <= 1'b0;
    end
  end

  // new protect code lands only when the cycle ends, so reads stay frozen
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      bp_reg <= `SEC_BP_RST;
    end else if (prog_done && stat_job_reg) begin
      bp_reg <= bp_pend_reg;
    end
  end

  // ----------------------------------------
  // programming cycle
  // ----------------------------------------
  wire f_in_valid = (prog_reg == sec_pkg::PROG_LOAD) && !load_idx_reg[4] &&
                    pmask_reg[load_idx_reg[PB-1:0]];
  wire [ADDR_W+7:0] f_in_data = {addr_reg[ADDR_W-1:PB], load_idx_reg[PB-1:0],
                                 pbuf[load_idx_reg[PB-1:0]]};
  wire f_out_ready = (pace_reg == 2'h0);

  sec_fifo #(
    .WIDTH(ADDR_W + 8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(I_REF_CLK),
    .rst_n(I_RST_N),
    .i_valid(f_in_valid),
    .o_ready(f_in_ready),
    .i_data(f_in_data),
    .o_valid(f_out_valid),
    .i_ready(f_out_ready),
    .o_data(f_out_data)
  );

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      prog_reg <= sec_pkg::PROG_IDLE;
      prog_cnt_reg <= 32'h0;
      load_idx_reg <= 5'h0;
      stat_job_reg <= 1'b0;
    end else begin
      if (prog_cnt_reg != 32'h0) begin
        prog_cnt_reg <= prog_cnt_reg - 1'b1;
      end
      case (prog_reg)
        sec_pkg::PROG_IDLE: begin
          load_idx_reg <= 5'h0;
          if (wr_commit || st_commit) begin
            prog_cnt_reg <= 32'(PROG_CYCLES);
            stat_job_reg <= st_commit;
            prog_reg <= wr_commit ? sec_pkg::PROG_LOAD : sec_pkg::PROG_TIME;
          end
        end
        sec_pkg::PROG_LOAD: begin
          // a full fifo holds the loader until the drain side catches up
          if (load_idx_reg == `SEC_PAGE_BYTES) begin
            prog_reg <= sec_pkg::PROG_TIME;
          end else if (!f_in_valid || f_in_ready) begin
            load_idx_reg <= load_idx_reg + 1'b1;
          end
        end
        sec_pkg::PROG_TIME: begin
          if (prog_done) begin
            prog_reg <= sec_pkg::PROG_IDLE;
          end
        end
        default: begin
          prog_reg <= sec_pkg::PROG_IDLE;
        end
      endcase
    end
  end

  // drain is paced slower than the loader, trading speed for a steady array port
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= (pace_reg == `SEC_DRAIN_PACE) ? 2'h0 : pace_reg + 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (f_out_valid && f_out_ready) begin
      mem[f_out_data[ADDR_W+7:8]] <= f_out_data[7:0];
    end
  end
endmodule

// ==== sim/sec_core_monitor.sv ====
`include "sec_cfg.svh"

module sec_core_monitor (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SDI,
  input wire logic I_WP_N,
  input wire logic O_SDO,
  input wire logic O_SDO_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  logic sck_reg;
  logic [4:0] cnt_reg;
  logic [7:0] op_reg;
  wire sck_rise = I_SCK && !sck_reg;
  wire op_hi_ok = op_reg[7:4] == `SEC_OP_HI;
  wire op_st = op_hi_ok && op_reg[2:0] == `SEC_OP_STATUS_READ;
  wire op_rd = op_hi_ok && op_reg[2:0] == `SEC_OP_ARRAY_READ;
  // saturates so long reads never alias back to the opcode count
  always_ff @(posedge I_REF_CLK) begin
    sck_reg <= I_SCK;
    if (I_CS_N || !I_RST_N) begin
      cnt_reg <= 5'h0;
    end else if (sck_rise && cnt_reg != 5'h1F) begin
      cnt_reg <= cnt_reg + 5'h1;
    end
    if (sck_rise && cnt_reg < 5'h8) begin
      op_reg <= {op_reg[6:0], I_SDI};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_cs_idle;
    I_CS_N [*5];
  endsequence
  sequence s_st_go;
    (op_st && cnt_reg == 5'h8 && !I_CS_N) [*8];
  endsequence
  property p_rst_idle;
    $rose(I_RST_N) |-> O_SDO_OE_N && !O_SDO;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("output active after reset");
  property p_idle_off;
    s_cs_idle |-> O_SDO_OE_N;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("output driven while deselected");
  property p_no_drive;
    $fell(O_SDO_OE_N) |-> !I_CS_N;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("output enabled without select");
  property p_hold;
    !O_SDO_OE_N && !I_CS_N |=> !O_SDO_OE_N;
  endproperty
  a_hold: assert property (p_hold)
    else $error("read dropped while selected");
  property p_sdo_stable;
    $rose(I_SCK) && !I_CS_N |=> (I_CS_N || $stable(O_SDO)) [*3];
  endproperty
  a_sdo_stable: assert property (p_sdo_stable)
    else $error("data out moved after rising clock");
  property p_bad_op;
    !I_CS_N && cnt_reg >= 5'h8 && !op_st && !op_rd |-> O_SDO_OE_N;
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("output driven for non-read opcode");
  property p_oe_when;
    $fell(O_SDO_OE_N) |-> (op_st && cnt_reg inside {5'h8, 5'h9})
      || (op_rd && cnt_reg inside {5'h10, 5'h11});
  endproperty
  a_oe_when: assert property (p_oe_when)
    else $error("output enabled at wrong bit count");
  property p_st_go;
    s_st_go |-> ##2 !O_SDO_OE_N;
  endproperty
  a_st_go: assert property (p_st_go)
    else $error("status read not answered");
endmodule

bind sec_core sec_core_monitor u_monitor (
  .I_REF_CLK(I_REF_CLK),
  .I_RST_N(I_RST_N),
  .I_CS_N(I_CS_N),
  .I_SCK(I_SCK),
  .I_SDI(I_SDI),
  .I_WP_N(I_WP_N),
  .O_SDO(O_SDO),
  .O_SDO_OE_N(O_SDO_OE_N)
);

// ==== sim/sec_spi_master.sv ====
module sec_spi_master (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idle_lvl = 1'b0;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // clock parks at the idle level of the mode, only between frames
  task automatic start(input int pol);
    idle_lvl = pol[0];
    o_sck = idle_lvl;
    tick(4);
    o_cs_n = 1'b0;
    tick(4);
  endtask
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_sck = 1'b0;
      o_sdi = tx[i];
      tick(4);
      o_sck = 1'b1;
      rx[i] = i_sdo;
      tick(4);
    end
  endtask
  task automatic stop();
    o_sck = idle_lvl;
    tick(2);
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    tick(6);
  endtask
endmodule

// ==== sim/sec_core_tb.sv ====
module sec_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic tgl = 1'b0;
  logic oe_seen = 1'b0;
  logic cs_n, sck, sdi, sdo, oe_n;
  logic [15:0] lfsr = 16'hD9F4;
  logic [7:0] mem_m [int];
  logic [7:0] bad [2] = '{8'h8B, 8'h07};
  int ps [4] = '{512, 384, 256, 0};
  int n_mismatch = 0;
  int n_tests = 0;
  int busy = 0;
  int write_enable_latch = 0;
  int bp = 0;
  int bp_vis = 0;
  int pol = 0;
  // released data line toggles so stale bits cannot pass
  wire sdo_line = oe_n ? tgl : sdo;
  always #12.5 clk = ~clk;
  always @(posedge clk) tgl <= ~tgl;
  always @(posedge clk) if (!oe_n) oe_seen <= 1'b1;
  sec_core #(.PROG_CYCLES(600)) uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
    .I_SCK(sck), .I_SDI(sdi), .I_WP_N(wp_n), .O_SDO(sdo), .O_SDO_OE_N(oe_n));
  sec_spi_master m (.i_clk(clk), .i_sdo(sdo_line), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  function automatic int prot(int a);
    return bp == 3 || (bp == 2 && a >= 256) || (bp == 1 && a >= 384);
  endfunction
  function automatic logic [7:0] st();
    return {4'hF, bp_vis[1:0], write_enable_latch[0], busy[0]};
  endfunction
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    m.start(pol);
    m.xbits(op, 8, r);
    m.stop();
  endtask
  task automatic rdst(output logic [7:0] s);
    logic [7:0] r;
    m.start(pol);
    m.xbits(8'h05, 8, r);
    m.xbits(8'h00, 8, s);
    m.stop();
  endtask
  task automatic poll();
    logic [7:0] s;
    int k;
    rdst(s);
    chk("status", st(), s);
    for (k = 0; k < 6 && s[0] !== 1'b0; k++) begin
      rdst(s);
      if (s[0] === 1'b0) begin
        busy = 0;
        write_enable_latch = 0;
        bp_vis = bp;
      end
      chk("status", st(), s);
    end
    if (s[0] !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic wr(input int a, input int n);
    logic [7:0] r, d;
    int ok, p;
    ok = write_enable_latch && !busy && wp_n && !prot(a);
    m.start(pol);
    m.xbits({4'h0, a[8], 3'h2}, 8, r);
    m.xbits(a[7:0], 8, r);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      m.xbits(d, 8, r);
      p = (a & 32'h1F0) | ((a + i) & 32'hF);
      if (ok) mem_m[p] = d;
    end
    m.stop();
    if (ok) busy = 1;
  endtask
  task automatic rd(input int a, input int n);
    logic [7:0] r;
    int p;
    oe_seen = 1'b0;
    m.start(pol);
    m.xbits({4'h0, a[8], 3'h3}, 8, r);
    m.xbits(a[7:0], 8, r);
    for (int i = 0; i < n; i++) begin
      m.xbits(8'h00, 8, r);
      p = (a + i) % 512;
      if (!busy && mem_m.exists(p)) chk("array", mem_m[p], r);
    end
    m.stop();
    if (busy) chk("read while busy", 8'h00, {7'h0, oe_seen});
  endtask
  task automatic status_write_cmd(input logic [7:0] d, input int nb);
    logic [7:0] r;
    m.start(pol);
    m.xbits(8'h01, 8, r);
    m.xbits(d, nb, r);
    m.stop();
    if (write_enable_latch && !busy && wp_n && nb == 8) begin
      bp = d[3:2];
      busy = 1;
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    poll();
    cmd(8'h0E);
    write_enable_latch = 1;
    poll();
    cmd(8'h04);
    write_enable_latch = 0;
    poll();
    wr(32'h1FC, 1);
    poll();
    cmd(8'h06);
    write_enable_latch = 1;
    wr(32'h1FC, 18);
    rd(32'h1FC, 1);
    wr(32'h000, 1);
    poll();
    cmd(8'h06);
    write_enable_latch = 1;
    wr(32'h000, 2);
    poll();
    pol = 1;
    rd(32'h1FC, 8);
    for (int c = 1; c < 4; c++) begin
      cmd(8'h06);
      write_enable_latch = 1;
      status_write_cmd({4'h0, c[1:0], 2'h3}, 8);
      poll();
      cmd(8'h06);
      write_enable_latch = 1;
      wr(ps[c], 1);
      poll();
      if (c < 3) begin
        wr(ps[c] - 1, 1);
        poll();
      end
    end
    rd(32'h000, 2);
    wp_n = 1'b0;
    write_enable_latch = 0;
    poll();
    cmd(8'h06);
    status_write_cmd(8'h00, 8);
    poll();
    wp_n = 1'b1;
    cmd(8'h06);
    write_enable_latch = 1;
    status_write_cmd(8'h00, 7);
    poll();
    status_write_cmd(8'h00, 8);
    poll();
    cmd(8'h06);
    write_enable_latch = 1;
    m.start(pol);
    m.xbits(8'h02, 8, r);
    m.xbits(8'h40, 8, r);
    m.xbits(rnd(), 8, r);
    m.xbits(8'h00, 4, r);
    m.stop();
    poll();
    cmd(8'h04);
    write_enable_latch = 0;
    foreach (bad[i]) begin
      oe_seen = 1'b0;
      m.start(pol);
      m.xbits(bad[i], 8, r);
      m.xbits(8'h06, 8, r);
      m.stop();
      chk("quiet", 8'h00, {7'h0, oe_seen});
    end
    poll();
    end_of_test();
  end
endmodule
